// file: rtl/eimso_unit.sv
// Execution unit for extended increment, invert, move and multi-register stack operations.
//
// Summary of operation
// - Single increment adds one, all sizes.
// - Word increment: carry only from 0FFFFh.
// - Word increment: overflow only from 07FFFh.
// - Double increment adds two, all sizes.
// - Word double increment carry from 0FFFEh/0FFFFh.
// - Word double increment zero only from 0FFFEh.
// - Word double increment overflow from 07FFEh/07FFFh.
// - Invert complements destination within operand size.
// - Invert carry equals not zero.
// - Invert overflow set if original negative.
// - Byte invert zero only from 0FFh.
// - Move copies source to destination, 20-bit space.
// - Address pop: two words, stack plus four.
// - Pop keeps flags unless status register restored.
// - Address push: full value, stack minus four.
// - Push upper bits first at higher address.
// - Push from named register, descending numbers.
// - Word push: stack minus two per register.
// - Push leaves source registers and flags unchanged.
// - Push needs no extension word.
`timescale 1ns/1ps
module eimso_unit
	import eimso_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              rst,
	// Operation request from the decoder.
	input  wire logic              op_start,
	input  wire logic [2:0]        op_code,
	input  wire logic [1:0]        op_size,
	input  wire logic [3:0]        op_reg,
	input  wire logic [4:0]        op_count,
	input  wire logic [ADDR_W-1:0] op_dst_addr,
	input  wire logic [ADDR_W-1:0] op_src_addr,
	// Direct register access for loading and inspection.
	input  wire logic              reg_wr,
	input  wire logic [3:0]        reg_wr_sel,
	input  wire logic [ADDR_W-1:0] reg_wr_data,
	input  wire logic [3:0]        reg_rd_sel,
	output logic      [ADDR_W-1:0] reg_rd_data,
	// Operation status.
	output logic                   op_busy,
	output logic                   op_done,
	output logic                   op_reject,
	// Memory bus.
	output logic      [ADDR_W-1:0] mem_addr,
	output logic      [DATA_W-1:0] mem_wdata,
	output logic                   mem_wr,
	output logic                   mem_rd,
	output logic                   mem_byte,
	input  wire logic [DATA_W-1:0] mem_rdata
);

	logic [ADDR_W-1:0] regs_ff [NREG];
	eimso_state_t      state_ff;
	logic [1:0]        size_ff;
	logic [2:0]        code_ff;
	logic [3:0]        cur_ff;
	logic [4:0]        left_ff;
	logic              half_ff;
	logic [ADDR_W-1:0] dst_ff;
	logic [DATA_W-1:0] lo_ff;
	logic [ADDR_W-1:0] reg_rd_data_ff;
	logic              busy_ff;
	logic              done_ff;
	logic              reject_ff;
	logic [ADDR_W-1:0] maddr_ff;
	logic [DATA_W-1:0] mwdata_ff;
	logic              mwr_ff;
	logic              mrd_ff;
	logic              mbyte_ff;
	logic              rd_pend_ff;

	// Arithmetic on a memory operand only (read then write back).
	logic [ADDR_W-1:0] mask;
	logic [ADDR_W-1:0] opnd;
	logic [ADDR_W-1:0] nxt_res;
	logic [ADDR_W-1:0] sp;
	logic              sign_in;
	logic              sign_out;
	logic              cout;
	logic [ADDR_W:0]   sum;
	logic [ADDR_W-1:0] nxt_flags;
	logic              cnt_ok;

	assign sp     = regs_ff[REG_SP];
	assign cnt_ok = (op_count >= CNT_MIN) && (op_count <= CNT_MAX);

	always_comb begin
		mask = (size_ff == SZ_BYTE) ? BYTE_MASK : (size_ff == SZ_WORD) ? WORD_MASK : ALL1_20;
		opnd = {4'h0, mem_rdata} & mask;
		sum  = {1'b0, opnd} + {1'b0, (code_ff == OP_INCD) ? TWO20 : ONE20};
		if (code_ff == OP_INV) begin
			nxt_res = (opnd ^ mask) & mask;
		end else begin
			nxt_res = sum[ADDR_W-1:0] & mask;
		end
		case (size_ff)
			SZ_BYTE: begin
				sign_in  = opnd[MSB_B];
				sign_out = nxt_res[MSB_B];
				cout     = sum[MSB_B+1];
			end
			SZ_WORD: begin
				sign_in  = opnd[MSB_W];
				sign_out = nxt_res[MSB_W];
				cout     = sum[MSB_W+1];
			end
			default: begin
				sign_in  = opnd[MSB_A];
				sign_out = nxt_res[MSB_A];
				cout     = sum[ADDR_W];
			end
		endcase
		nxt_flags         = regs_ff[REG_SR];
		nxt_flags[FLAG_N] = sign_out;
		nxt_flags[FLAG_Z] = (nxt_res == '0);
		if (code_ff == OP_INV) begin
			nxt_flags[FLAG_C] = (nxt_res != '0);
			nxt_flags[FLAG_V] = sign_in;
		end else begin
			nxt_flags[FLAG_C] = cout;
			nxt_flags[FLAG_V] = ~sign_in & sign_out;
		end
	end

	// Sequencer. A memory read is issued one cycle and its data is used the cycle after.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff   <= EIMSO_IDLE;
			size_ff    <= SZ_WORD;
			code_ff    <= OP_INC;
			cur_ff     <= 4'h0;
			left_ff    <= 5'h00;
			half_ff    <= 1'b0;
			dst_ff     <= '0;
			lo_ff      <= '0;
			busy_ff    <= 1'b0;
			done_ff    <= 1'b0;
			reject_ff  <= 1'b0;
			maddr_ff   <= '0;
			mwdata_ff  <= '0;
			mwr_ff     <= 1'b0;
			mrd_ff     <= 1'b0;
			mbyte_ff   <= 1'b0;
			rd_pend_ff <= 1'b0;
			for (int i = 0; i < NREG; i++) begin
				regs_ff[i] <= '0;
			end
		end else begin
			done_ff   <= 1'b0;
			reject_ff <= 1'b0;
			mwr_ff    <= 1'b0;
			mrd_ff    <= 1'b0;
			if (reg_wr && state_ff == EIMSO_IDLE) begin
				regs_ff[reg_wr_sel] <= reg_wr_data;
			end
			case (state_ff)
				EIMSO_IDLE: begin
					if (op_start) begin
						size_ff <= op_size;
						code_ff <= op_code;
						dst_ff  <= op_dst_addr;
						half_ff <= 1'b0;
						if ((op_code == OP_MULTI_REGISTER_PUSH || op_code == OP_POPM) && !cnt_ok) begin
							reject_ff <= 1'b1;
						end else begin
							busy_ff <= 1'b1;
							case (op_code)
								OP_MULTI_REGISTER_PUSH: begin
									// Count and size come straight from the request.
									cur_ff   <= op_reg;
									left_ff  <= op_count;
									state_ff <= EIMSO_PUSH;
								end
								OP_POPM: begin
									cur_ff   <= 4'(op_reg - 4'(op_count - 5'h01));
									left_ff  <= op_count;
									state_ff <= EIMSO_POP;
								end
								OP_MOVE: begin
									maddr_ff   <= op_src_addr;
									mrd_ff     <= 1'b1;
									mbyte_ff   <= (op_size == SZ_BYTE);
									rd_pend_ff <= 1'b1;
									state_ff   <= EIMSO_MOVR;
								end
								OP_INC, OP_INCD, OP_INV: begin
									maddr_ff   <= op_dst_addr;
									mrd_ff     <= 1'b1;
									mbyte_ff   <= (op_size == SZ_BYTE);
									rd_pend_ff <= 1'b1;
									state_ff   <= EIMSO_MOVR;
								end
								default: begin
									busy_ff   <= 1'b0;
									reject_ff <= 1'b1;
								end
							endcase
						end
					end
				end
				EIMSO_PUSH: begin
					// Pushed registers are only read here; only the stack pointer is written.
					mwr_ff   <= 1'b1;
					mbyte_ff <= 1'b0;
					if (size_ff == SZ_ADDR && !half_ff) begin
						maddr_ff  <= ADDR_W'(sp - SP_STEP_W);
						mwdata_ff <= {12'h000, regs_ff[cur_ff][ADDR_W-1:DATA_W]};
						half_ff   <= 1'b1;
					end else begin
						if (size_ff == SZ_ADDR) begin
							maddr_ff             <= ADDR_W'(sp - SP_STEP_A);
							regs_ff[REG_SP]      <= ADDR_W'(sp - SP_STEP_A);
						end else begin
							maddr_ff             <= ADDR_W'(sp - SP_STEP_W);
							regs_ff[REG_SP]      <= ADDR_W'(sp - SP_STEP_W);
						end
						mwdata_ff <= regs_ff[cur_ff][DATA_W-1:0];
						half_ff   <= 1'b0;
						cur_ff    <= 4'(cur_ff - 4'h1);
						left_ff   <= 5'(left_ff - 5'h01);
						if (left_ff == CNT_MIN) begin
							state_ff <= EIMSO_DONE;
						end
					end
				end
				EIMSO_POP: begin
					if (!rd_pend_ff) begin
						maddr_ff   <= half_ff ? ADDR_W'(sp + SP_STEP_W) : sp;
						mrd_ff     <= 1'b1;
						mbyte_ff   <= 1'b0;
						rd_pend_ff <= 1'b1;
					end else if (mrd_ff) begin
						// The read strobe is still out; its data arrives one cycle later.
						rd_pend_ff <= 1'b1;
					end else begin
						rd_pend_ff <= 1'b0;
						if (size_ff == SZ_ADDR && !half_ff) begin
							lo_ff   <= mem_rdata;
							half_ff <= 1'b1;
						end else begin
							// Flags change only when the status register itself is restored.
							if (size_ff == SZ_ADDR) begin
								regs_ff[cur_ff]      <= {mem_rdata[3:0], lo_ff};
								regs_ff[REG_SP]      <= ADDR_W'(sp + SP_STEP_A);
							end else begin
								regs_ff[cur_ff]      <= {4'h0, mem_rdata};
								regs_ff[REG_SP]      <= ADDR_W'(sp + SP_STEP_W);
							end
							half_ff <= 1'b0;
							cur_ff  <= 4'(cur_ff + 4'h1);
							left_ff <= 5'(left_ff - 5'h01);
							if (left_ff == CNT_MIN) begin
								state_ff <= EIMSO_DONE;
							end
						end
					end
				end
				EIMSO_MOVR: begin
					// Second cycle: data from the read is valid; write the result.
					if (rd_pend_ff) begin
						rd_pend_ff <= 1'b0;
					end else begin
						mwr_ff   <= 1'b1;
						maddr_ff <= dst_ff;
						if (code_ff == OP_MOVE) begin
							mwdata_ff <= mem_rdata & mask[DATA_W-1:0];
						end else begin
							mwdata_ff        <= nxt_res[DATA_W-1:0];
							regs_ff[REG_SR]  <= nxt_flags;
						end
						state_ff <= EIMSO_DONE;
					end
				end
				EIMSO_DONE: begin
					busy_ff  <= 1'b0;
					done_ff  <= 1'b1;
					state_ff <= EIMSO_IDLE;
				end
				default: begin
					state_ff <= EIMSO_IDLE;
					busy_ff  <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rd_data_ff <= '0;
		end else begin
			reg_rd_data_ff <= regs_ff[reg_rd_sel];
		end
	end

	assign reg_rd_data = reg_rd_data_ff;
	assign op_busy     = busy_ff;
	assign op_done     = done_ff;
	assign op_reject   = reject_ff;
	assign mem_addr    = maddr_ff;
	assign mem_wdata   = mwdata_ff;
	assign mem_wr      = mwr_ff;
	assign mem_rd      = mrd_ff;
	assign mem_byte    = mbyte_ff;

endmodule

// file: rtl/eimso_pkg.sv
// Package with operation codes, sizes and constants of the extended operation unit.
package eimso_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int NREG   = 16;

	// Operation select codes.
	localparam logic [2:0] OP_INC   = 3'h0;
	localparam logic [2:0] OP_INCD  = 3'h1;
	localparam logic [2:0] OP_INV   = 3'h2;
	localparam logic [2:0] OP_MOVE  = 3'h3;
	localparam logic [2:0] OP_MULTI_REGISTER_PUSH = 3'h4;
	localparam logic [2:0] OP_POPM  = 3'h5;

	// Operand size codes.
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_ADDR = 2'h2;

	// Register numbers with dedicated use.
	localparam logic [3:0] REG_SP = 4'h1;
	localparam logic [3:0] REG_SR = 4'h2;

	// Status register flag positions.
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 8;

	// Constants of the arithmetic.
	localparam logic [19:0] ONE20      = 20'h00001;
	localparam logic [19:0] TWO20      = 20'h00002;
	localparam logic [19:0] ALL1_20    = 20'hFFFFF;
	localparam logic [19:0] BYTE_MASK  = 20'h000FF;
	localparam logic [19:0] WORD_MASK  = 20'h0FFFF;
	localparam logic [19:0] SP_STEP_W  = 20'h00002;
	localparam logic [19:0] SP_STEP_A  = 20'h00004;
	localparam logic [4:0]  CNT_MIN    = 5'h01;
	localparam logic [4:0]  CNT_MAX    = 5'h10;
	localparam int          MSB_B      = 7;
	localparam int          MSB_W      = 15;
	localparam int          MSB_A      = 19;

	typedef enum logic [5:0] {
		EIMSO_IDLE  = 6'h01,
		EIMSO_PUSH  = 6'h02,
		EIMSO_POP   = 6'h04,
		EIMSO_POPHI = 6'h08,
		EIMSO_MOVR  = 6'h10,
		EIMSO_DONE  = 6'h20
	} eimso_state_t;
endpackage

// file: tb/eimso_unit_properties.sv
// Checker of the unit's port timing.
`timescale 1ns/1ps
module eimso_unit_properties
	import eimso_pkg::*;
(
	// Watched ports.
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       op_start,
	input wire logic [2:0] op_code,
	input wire logic [4:0] op_count,
	input wire logic       op_busy,
	input wire logic       op_done,
	input wire logic       op_reject,
	input wire logic       mem_wr,
	input wire logic       mem_rd
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic take;
	logic stk;
	logic cnt_ok;
	assign take   = op_start && !op_busy && !op_done;
	assign stk    = op_code == OP_MULTI_REGISTER_PUSH || op_code == OP_POPM;
	assign cnt_ok = op_count >= CNT_MIN && op_count <= CNT_MAX;
	// Read, data, write and done each own one fixed slot.
	sequence rmw_seq;
		mem_rd ##2 mem_wr ##1 op_done;
	endsequence
	a_rmw_timing: assert property (take && op_code < OP_MULTI_REGISTER_PUSH |=> rmw_seq)
		else $error("operand steps out of order");
	a_bad_count: assert property (take && stk && !cnt_ok |=> op_reject && !op_busy && !mem_wr && !mem_rd)
		else $error("bad count not refused");
	a_good_count: assert property (take && stk && cnt_ok |=> !op_reject)
		else $error("legal count refused");
	a_stack_ends: assert property (take && stk && cnt_ok |-> ##[1:200] op_done)
		else $error("stack operation hung");
	a_push_no_read: assert property (take && op_code == OP_MULTI_REGISTER_PUSH && cnt_ok |=> !mem_rd until op_done)
		else $error("push read memory");
	a_pop_no_write: assert property (take && op_code == OP_POPM && cnt_ok |=> !mem_wr until op_done)
		else $error("pop wrote memory");
	a_idle_quiet: assert property (!op_busy |-> !mem_wr && !mem_rd)
		else $error("strobe while idle");
	a_strobe_excl: assert property (!(mem_wr && mem_rd))
		else $error("read and write together");
endmodule

// file: tb/eimso_mem_model.sv
// Behavioural word memory on the far side of the unit's bus.
`timescale 1ns/1ps
module eimso_mem_model
	import eimso_pkg::*;
(
	// Bus from the unit.
	input  wire logic              clk,
	input  wire logic [ADDR_W-1:0] mem_addr,
	input  wire logic [DATA_W-1:0] mem_wdata,
	input  wire logic              mem_wr,
	input  wire logic              mem_rd,
	input  wire logic              mem_byte,
	output logic      [DATA_W-1:0] mem_rdata
);
	logic [DATA_W-1:0] m [256];
	// Only bits 8:1 decode. Read data flip after their one cycle, so a late sample fails.
	always @(posedge clk) begin
		if (mem_wr && mem_byte)
			m[mem_addr[8:1]][7:0] <= mem_wdata[7:0];
		else if (mem_wr)
			m[mem_addr[8:1]] <= mem_wdata;
		mem_rdata <= mem_rd ? m[mem_addr[8:1]] : ~mem_rdata;
	end
endmodule

// file: tb/tb_top.sv
// Bench for the extended operation unit.
`timescale 1ns/1ps
module tb_top
	import eimso_pkg::*;
;
	logic        clk, rst, op_start, reg_wr, op_busy, op_done, op_reject, mem_wr, mem_rd, mem_byte, rj;
	logic [2:0]  op_code;
	logic [1:0]  op_size;
	logic [3:0]  op_reg, reg_wr_sel, reg_rd_sel;
	logic [4:0]  op_count;
	logic [19:0] op_dst_addr, op_src_addr, reg_wr_data, reg_rd_data, mem_addr, v;
	logic [15:0] mem_wdata, mem_rdata;
	int          fail_count, num_checks;
	// Rows: op, size, start word, result word, flags V Z C.
	logic [39:0] rows [10] = '{{OP_INC, SZ_WORD, 16'hFFFF, 16'h0000, 3'h3}, {OP_INC, SZ_WORD, 16'h7FFF, 16'h8000, 3'h4},
		{OP_INCD, SZ_WORD, 16'hFFFE, 16'h0000, 3'h3}, {OP_INCD, SZ_WORD, 16'hFFFF, 16'h0001, 3'h1},
		{OP_INCD, SZ_WORD, 16'h7FFE, 16'h8000, 3'h4}, {OP_INCD, SZ_WORD, 16'h7FFF, 16'h8001, 3'h4},
		{OP_INV, SZ_WORD, 16'hFFFF, 16'h0000, 3'h6}, {OP_INV, SZ_WORD, 16'h0000, 16'hFFFF, 3'h1},
		{OP_INV, SZ_WORD, 16'h8000, 16'h7FFF, 3'h5}, {OP_INV, SZ_BYTE, 16'h00FF, 16'h0000, 3'h6}};
	eimso_unit uut (.clk, .rst, .op_start, .op_code, .op_size, .op_reg, .op_count, .op_dst_addr, .op_src_addr, .reg_wr,
		.reg_wr_sel, .reg_wr_data, .reg_rd_sel, .reg_rd_data, .op_busy, .op_done, .op_reject, .mem_addr, .mem_wdata,
		.mem_wr, .mem_rd, .mem_byte, .mem_rdata);
	eimso_mem_model mem (.clk, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_byte, .mem_rdata);
	task automatic chk(input logic [19:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr_reg(input logic [3:0] s, input logic [19:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_wr_sel <= s;
		reg_wr_data <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] s, output logic [19:0] d);
		@(posedge clk);
		reg_rd_sel <= s;
		repeat (2) @(posedge clk);
		#1 d = reg_rd_data;
	endtask
	task automatic run_op(input logic [2:0] c, input logic [1:0] s, input logic [3:0] r, input logic [4:0] n,
			input logic [19:0] d);
		@(posedge clk);
		op_start <= 1'b1;
		op_code <= c;
		op_size <= s;
		op_reg <= r;
		op_count <= n;
		op_dst_addr <= d;
		@(posedge clk);
		op_start <= 1'b0;
		#1;
		// A hung operation ends the run instead of stalling it.
		for (int k = 0; !(op_done === 1'b1 || op_reject === 1'b1); k++) begin
			if (k == 200) begin
				fail_count++;
				summarize();
			end
			@(posedge clk);
			#1;
		end
		rj = op_reject;
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		{op_start, op_code, op_size, op_reg, op_count, op_dst_addr, reg_wr, reg_wr_sel, reg_wr_data, reg_rd_sel} = '0;
		op_src_addr = 20'h00082;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 chk({17'h0, op_busy, op_done, op_reject}, 20'h0);
		rd_reg(REG_SR, v);
		chk(v, 20'h0);
		$display("reset test done");
		for (int i = 0; i < 10; i++) begin
			mem.m[8'h80] = rows[i][34:19];
			run_op(rows[i][39:37], rows[i][36:35], 4'h0, 5'h00, 20'h00100);
			rd_reg(REG_SR, v);
			chk({4'h0, mem.m[8'h80]}, {4'h0, rows[i][18:3]});
			chk({17'h0, v[FLAG_V], v[FLAG_Z], v[FLAG_C]}, {17'h0, rows[i][2:0]});
			$display("row %0d done", i);
		end
		mem.m[8'h41] = 16'h5A3C;
		run_op(OP_MOVE, SZ_WORD, 4'h0, 5'h00, 20'hF0080);
		chk({4'h0, mem.m[8'h40]}, 20'h05A3C);
		chk({4'h0, mem.m[8'h41]}, 20'h05A3C);
		rd_reg(REG_SR, v);
		chk(v, 20'h00102);
		$display("move test done");
		wr_reg(REG_SP, 20'h00200);
		wr_reg(4'hD, 20'hABCDE);
		wr_reg(4'hC, 20'h12345);
		run_op(OP_MULTI_REGISTER_PUSH, SZ_ADDR, 4'hD, 5'h02, 20'h0);
		chk({4'h0, mem.m[8'hFF]}, 20'h0000A);
		chk({4'h0, mem.m[8'hFE]}, 20'h0BCDE);
		chk({4'h0, mem.m[8'hFD]}, 20'h00001);
		chk({4'h0, mem.m[8'hFC]}, 20'h02345);
		rd_reg(4'hD, v);
		chk(v, 20'hABCDE);
		rd_reg(REG_SP, v);
		chk(v, 20'h001F8);
		run_op(OP_POPM, SZ_ADDR, 4'h5, 5'h02, 20'h0);
		rd_reg(4'h4, v);
		chk(v, 20'h12345);
		rd_reg(4'h5, v);
		chk(v, 20'hABCDE);
		rd_reg(REG_SP, v);
		chk(v, 20'h00200);
		$display("address stack test done");
		wr_reg(4'h6, 20'hF0000);
		run_op(OP_MULTI_REGISTER_PUSH, SZ_WORD, 4'h5, 5'h01, 20'h0);
		chk({4'h0, mem.m[8'hFF]}, 20'h0BCDE);
		run_op(OP_POPM, SZ_WORD, 4'h6, 5'h01, 20'h0);
		rd_reg(4'h6, v);
		chk(v, 20'h0BCDE);
		wr_reg(REG_SP, 20'h001FE);
		mem.m[8'hFF] = 16'h0103;
		run_op(OP_POPM, SZ_WORD, REG_SR, 5'h01, 20'h0);
		rd_reg(REG_SR, v);
		chk(v, 20'h00103);
		$display("word stack test done");
		for (int i = 0; i < 3; i++) begin
			run_op(OP_MULTI_REGISTER_PUSH, SZ_WORD, 4'hF, i == 0 ? 5'h00 : i == 1 ? 5'h11 : 5'h10, 20'h0);
			chk({19'h0, rj}, {19'h0, i < 2});
		end
		rd_reg(REG_SP, v);
		chk(v, 20'h001E0);
		$display("count test done");
		summarize();
	end
endmodule
bind eimso_unit eimso_unit_properties u_props (.clk, .rst, .op_start, .op_code, .op_count, .op_busy, .op_done,
	.op_reject, .mem_wr, .mem_rd);
